// ---- design/acps_port.v ----
// serial port control: register steering, clock mode, filter sync, burnout switch
// assumes sys_clk 200 MHz; all pins below except conv_data and conv_valid are asynchronous to it
// conv_data and conv_valid come from sys_clk logic, not synchronised
`timescale 1ns/1ps
`include "acps_regs.vh"

// Overview of operation
// [R1] select low: transfers use control register
// [R2] select high: data read, calibration write
// [R3] sync input resets digital filter nodes
// [R4] mode high: device makes serial clock
// [R5] mode low: host supplies serial clock
// [R6] control bit switches burnout current source
// [R7] host clock continuous or in bursts
// [R8] clock pin driven only in self mode
module acps_port #(
  parameter WORD_W   = `ACPS_WORD_W,
  parameter HALF_CYC = `ACPS_SCLK_HALF_CYC
) (
  input  wire              sys_clk,
  input  wire              arst_n,
  input  wire              register_select,
  input  wire              mode_self,
  input  wire              sync_n,
  input  wire              read_frame_n,
  input  wire              write_frame_n,
  input  wire              sclk_in,
  output reg               sclk_out,
  output reg               sclk_oe,
  input  wire              sdata_in,
  output reg               sdata_out,
  output reg               sdata_oe,
  input  wire [WORD_W-1:0] conv_data,
  input  wire              conv_valid,
  output reg               filter_reset,
  output reg               burnout_en,
  output reg  [WORD_W-1:0] ctrl_word,
  output reg  [WORD_W-1:0] cal_word
);

  // ==========================================================
  // pin synchronisers
  // reset to idle-high so no false frame edge follows reset
  reg  [6:0] s1;
  reg  [6:0] s2;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 7'h7f;
      s2 <= 7'h7f;
    end else begin
      s1 <= {register_select, mode_self, sync_n, read_frame_n, write_frame_n, sclk_in, sdata_in};
      s2 <= s1;
    end
  end
  wire sel_s   = s2[6];
  wire mode_s  = s2[5];
  wire sync_s  = s2[4];
  wire rfs_s   = s2[3];
  wire tfs_s   = s2[2];
  wire sclk_s  = s2[1];
  wire sdin_s  = s2[0];

  // ==========================================================
  // frame edges and clock edge detection
  reg                   rfs_d;
  reg                   tfs_d;
  reg                   sclk_d;
  reg                   in_read;
  reg                   in_write;
  reg                   sel_lat;
  reg                   self_lat;
  reg  [`ACPS_CNT_W-1:0] bit_cnt;
  reg  [`ACPS_DIV_W-1:0] div_cnt;
  reg  [WORD_W-1:0]     sh;
  reg  [WORD_W-1:0]     data_reg;

  // counter steps and end points
  localparam [`ACPS_CNT_W-1:0] CNT_STEP = {{(`ACPS_CNT_W-1){1'b0}}, 1'b1};
  localparam [`ACPS_CNT_W-1:0] CNT_LAST = WORD_W[`ACPS_CNT_W-1:0];
  localparam [`ACPS_DIV_W-1:0] DIV_STEP = {{(`ACPS_DIV_W-1){1'b0}}, 1'b1};
  localparam [`ACPS_DIV_W-1:0] DIV_LAST = HALF_CYC[`ACPS_DIV_W-1:0] - DIV_STEP;

  // read wins when both frame edges land together
  wire rd_start = rfs_d & ~rfs_s & ~in_write;
  wire wr_start = tfs_d & ~tfs_s & ~in_read & ~rd_start;
  wire active   = in_read | in_write;
  wire more     = (bit_cnt != CNT_LAST);
  wire div_hit  = (div_cnt == DIV_LAST);

  // host clock must stay high and low four cycles each
  // [R5] host clock edges when external
  wire ext_rise = ~self_lat & ~sclk_d & sclk_s;
  wire ext_fall = ~self_lat & sclk_d & ~sclk_s;
  // rise needs no bit left so the last fall returns high
  // [R4] own divider edges when self-clocked
  wire int_rise = self_lat & active & div_hit & ~sclk_out;
  wire int_fall = self_lat & active & div_hit & sclk_out;
  wire rise_ev  = ext_rise | int_rise;
  wire fall_ev  = ext_fall | int_fall;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rfs_d  <= 1'b1;
      tfs_d  <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      rfs_d  <= rfs_s;
      tfs_d  <= tfs_s;
      sclk_d <= sclk_s;
    end
  end

  // ==========================================================
  // conversion result holding
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= `ACPS_DATA_RST;
    end else if (conv_valid && !in_read) begin
      // no update mid-read so a word never tears
      data_reg <= conv_data;
    end
  end

  // ==========================================================
  // frame and shift control
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_read   <= 1'b0;
      in_write  <= 1'b0;
      sel_lat   <= `ACPS_SEL_CTRL;
      self_lat  <= 1'b0;
      bit_cnt   <= {`ACPS_CNT_W{1'b0}};
      sh        <= {WORD_W{1'b0}};
      ctrl_word <= `ACPS_CTRL_RST;
      cal_word  <= `ACPS_CAL_RST;
    end else if (rd_start) begin
      in_read  <= 1'b1;
      sel_lat  <= sel_s;
      self_lat <= (mode_s == `ACPS_MODE_SELF);
      bit_cnt  <= {`ACPS_CNT_W{1'b0}};
      // [R1] control register read when low
      // [R2] data register read when high
      sh       <= (sel_s == `ACPS_SEL_CTRL) ? ctrl_word : data_reg;
    end else if (wr_start) begin
      in_write <= 1'b1;
      sel_lat  <= sel_s;
      self_lat <= (mode_s == `ACPS_MODE_SELF);
      bit_cnt  <= {`ACPS_CNT_W{1'b0}};
    end else begin
      if (in_read && rfs_s) begin
        in_read <= 1'b0;
      end
      if (in_write && tfs_s) begin
        in_write <= 1'b0;
      end
      // [R7] count survives pauses between bursts
      if (in_read && fall_ev && more) begin
        sh      <= {sh[WORD_W-2:0], 1'b0};
        bit_cnt <= bit_cnt + CNT_STEP;
      end
      // self-clocked write reads the data pin two cycles late
      if (in_write && rise_ev && more) begin
        sh      <= {sh[WORD_W-2:0], sdin_s};
        bit_cnt <= bit_cnt + CNT_STEP;
        if (bit_cnt == CNT_LAST - CNT_STEP) begin
          // [R1] control register written when low
          if (sel_lat == `ACPS_SEL_CTRL) begin
            ctrl_word <= {sh[WORD_W-2:0], sdin_s};
          end else begin
            // [R2] calibration register written when high
            cal_word <= {sh[WORD_W-2:0], sdin_s};
          end
        end
      end
    end
  end

  // ==========================================================
  // clock divider and pin drivers
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt   <= {`ACPS_DIV_W{1'b0}};
      sclk_out  <= 1'b1;
      sclk_oe   <= 1'b0;
      sdata_out <= 1'b0;
      sdata_oe  <= 1'b0;
    end else begin
      if (!(self_lat && active) || div_hit) begin
        div_cnt <= {`ACPS_DIV_W{1'b0}};
      end else begin
        div_cnt <= div_cnt + DIV_STEP;
      end
      // [R8] clock pin driven in self mode only
      sclk_oe <= self_lat & active;
      // device clock idles high outside frames
      if (!(self_lat && active)) begin
        sclk_out <= 1'b1;
      end else if (int_rise) begin
        sclk_out <= 1'b1;
      end else if (int_fall && more) begin
        sclk_out <= 1'b0;
      end
      sdata_oe  <= in_read & ~rfs_s;
      // msb presented at frame start, next bit after each falling edge
      sdata_out <= sh[WORD_W-1];
    end
  end

  // ==========================================================
  // filter sync and burnout source
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      filter_reset <= 1'b0;
      burnout_en   <= 1'b0;
    end else begin
      // [R3] filter held in reset while sync low
      filter_reset <= ~sync_s;
      // [R6] burnout follows its control bit
      burnout_en   <= ctrl_word[`ACPS_BURNOUT_BIT];
    end
  end

endmodule // acps_port

// ---- inc/acps_regs.vh ----
// constants for the converter serial port control block
// assumes inclusion by bare name from design files
`ifndef ACPS_REGS_VH
`define ACPS_REGS_VH
`define ACPS_WORD_W        24
`define ACPS_CNT_W         5
`define ACPS_CTRL_RST      24'h000000
`define ACPS_CAL_RST       24'h000000
`define ACPS_DATA_RST      24'h000000
`define ACPS_BURNOUT_BIT   13
`define ACPS_SCLK_HALF_NS  40
`define ACPS_SYS_PERIOD_NS 5
`define ACPS_SCLK_HALF_CYC (`ACPS_SCLK_HALF_NS / `ACPS_SYS_PERIOD_NS)
`define ACPS_DIV_W         8
`define ACPS_SEL_CTRL      1'b0
`define ACPS_MODE_SELF     1'b1
`endif

// ---- tb/acps_assertions.sv ----
// checker for the serial port control block
// assumes bound to acps_port, sys_clk domain only
`timescale 1ns/1ps
module acps_chk #(parameter WORD_W = 24) (
  input wire              sys_clk,
  input wire              arst_n,
  input wire              register_select,
  input wire              mode_self,
  input wire              sync_n,
  input wire              read_frame_n,
  input wire              sdata_oe,
  input wire              sclk_oe,
  input wire              filter_reset,
  input wire              burnout_en,
  input wire [WORD_W-1:0] ctrl_word,
  input wire [WORD_W-1:0] cal_word
);
  // ====
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ctrl_sel_a: assert property (!$stable(ctrl_word) |-> !$past(register_select, 4))
    else $error("control written with select high");
  cal_sel_a: assert property (!$stable(cal_word) |-> $past(register_select, 4))
    else $error("calibration written with select low");
  filt_set_a: assert property ($fell(sync_n) |-> ##[1:4] filter_reset)
    else $error("filter reset late");
  filt_clr_a: assert property ((sync_n) [*6] |-> !filter_reset)
    else $error("filter reset stuck");
  self_clk_a: assert property (mode_self && $fell(read_frame_n) |-> ##[2:8] sclk_oe)
    else $error("self clock not driven");
  ext_clk_a: assert property ((!mode_self) [*8] |-> !sclk_oe)
    else $error("clock pin driven in external mode");
  burn_track_a: assert property ($stable(ctrl_word) [*2] |-> burnout_en == ctrl_word[13])
    else $error("burnout switch wrong");
  read_oe_a: assert property ((!read_frame_n) [*6] |-> sdata_oe)
    else $error("data pin not driven in read frame");
  idle_oe_a: assert property ((read_frame_n) [*6] |-> !sdata_oe)
    else $error("data pin driven outside read frame");
  cover property ($rose(filter_reset));
  cover property ($rose(sclk_oe));
  cover property ($rose(burnout_en));
endmodule // acps_chk
bind acps_port acps_chk #(.WORD_W(WORD_W)) chk (
  .sys_clk         (sys_clk),
  .arst_n          (arst_n),
  .register_select (register_select),
  .mode_self       (mode_self),
  .sync_n          (sync_n),
  .read_frame_n    (read_frame_n),
  .sdata_oe        (sdata_oe),
  .sclk_oe         (sclk_oe),
  .filter_reset    (filter_reset),
  .burnout_en      (burnout_en),
  .ctrl_word       (ctrl_word),
  .cal_word        (cal_word)
);

// ---- tb/acps_host.sv ----
// host model: frames and external serial clock
// assumes pin levels resolved by the bench
`timescale 1ns/1ps
module acps_host (
  output reg  hclk,
  output reg  hdat,
  output reg  read_frame_n,
  output reg  write_frame_n,
  input  wire sclk_out,
  input  wire sdata_out
);
  integer i;
  initial begin
    {hclk, hdat, read_frame_n, write_frame_n} = 4'hf;
  end
  // bursts: pause mid word, clock idles high
  task wr(input [23:0] w, input integer n);
    begin
      write_frame_n = 0;
      #64;
      for (i = 0; i < n; i = i + 1) begin
        hclk = 0;
        hdat = w[23-i];
        #32 hclk = 1;
        #32;
        if (i == 11) #($urandom_range(40, 400));
      end
      hdat = ~hdat;
      #64 write_frame_n = 1;
      #96;
    end
  endtask
  task rd(output [23:0] r);
    begin
      read_frame_n = 0;
      #64;
      for (i = 0; i < 24; i = i + 1) begin
        r[23-i] = sdata_out;
        hclk = 0;
        #32 hclk = 1;
        #32;
      end
      read_frame_n = 1;
      #96;
    end
  endtask
  // self clocked read: device makes 24 falls
  task srd(output [23:0] r);
    begin
      read_frame_n = 0;
      for (i = 0; i < 24; i = i + 1) begin
        @(negedge sclk_out);
        r[23-i] = sdata_out;
      end
      #202 read_frame_n = 1;
      #100;
    end
  endtask
endmodule // acps_host

// ---- tb/testbench.sv ----
// self-checking bench for acps_port
// assumes host model drives frames and link clock
`timescale 1ns/1ps
module testbench;
  reg         sys_clk = 0, arst_n = 0, register_select = 0, mode_self = 0, sync_n = 1, conv_valid = 0;
  reg  [23:0] conv_data = 0, w, r, exp_ctrl = 0, exp_cal = 0, exp_data = 0;
  wire        read_frame_n, write_frame_n, hclk, hdat, sclk_out, sclk_oe, sdata_out, sdata_oe;
  wire        filter_reset, burnout_en;
  wire [23:0] ctrl_word, cal_word;
  wire        sclk_in = sclk_oe ? sclk_out : hclk;
  wire        sdata_in = sdata_oe ? sdata_out : hdat;
  integer     err_total = 0, check_count = 0, cyc = 0, k;
  always #2.5 sys_clk = ~sys_clk;
  acps_port DUT (
    .sys_clk         (sys_clk),
    .arst_n          (arst_n),
    .register_select (register_select),
    .mode_self       (mode_self),
    .sync_n          (sync_n),
    .read_frame_n    (read_frame_n),
    .write_frame_n   (write_frame_n),
    .sclk_in         (sclk_in),
    .sclk_out        (sclk_out),
    .sclk_oe         (sclk_oe),
    .sdata_in        (sdata_in),
    .sdata_out       (sdata_out),
    .sdata_oe        (sdata_oe),
    .conv_data       (conv_data),
    .conv_valid      (conv_valid),
    .filter_reset    (filter_reset),
    .burnout_en      (burnout_en),
    .ctrl_word       (ctrl_word),
    .cal_word        (cal_word)
  );
  acps_host host (
    .hclk            (hclk),
    .hdat            (hdat),
    .read_frame_n    (read_frame_n),
    .write_frame_n   (write_frame_n),
    .sclk_out        (sclk_out),
    .sdata_out       (sdata_out)
  );
  task chk(input [23:0] e, input [23:0] s, input string nm);
    begin
      check_count = check_count + 1;
      if (e !== s) begin
        err_total = err_total + 1;
        $display("mismatch %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // ====
  // timeout well above some 5000 cycles of traffic
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  initial begin
    k = $urandom(32'h10fa);
    repeat (20) @(negedge sys_clk);
    arst_n = 1;
    repeat (4) @(negedge sys_clk);
    for (k = 0; k < 4; k = k + 1) begin
      w = $urandom;
      w[13] = k[0];
      register_select = k[1];
      repeat (4) @(negedge sys_clk);
      host.wr(w, 24);
      if (k[1]) exp_cal = w;
      else exp_ctrl = w;
      // short write must leave registers alone
      host.wr(~w, 12);
      @(negedge sys_clk) conv_data = $urandom;
      conv_valid = 1;
      exp_data = conv_data;
      @(negedge sys_clk) conv_valid = 0;
      repeat (8) @(negedge sys_clk);
      chk(exp_ctrl, ctrl_word, "ctrl_word");
      chk(exp_cal, cal_word, "cal_word");
      chk({23'h0, exp_ctrl[13]}, {23'h0, burnout_en}, "burnout_en");
      host.rd(r);
      chk(k[1] ? exp_data : exp_ctrl, r, "read word");
    end
    sync_n = 0;
    repeat (5) @(negedge sys_clk);
    chk(24'h1, {23'h0, filter_reset}, "filter_reset");
    sync_n = 1;
    repeat (5) @(negedge sys_clk);
    chk(24'h0, {23'h0, filter_reset}, "filter_reset");
    mode_self = 1;
    repeat (4) @(negedge sys_clk);
    host.srd(r);
    chk(exp_data, r, "self read word");
    mode_self = 0;
    repeat (10) @(negedge sys_clk);
    chk(24'h0, {23'h0, sclk_oe}, "sclk_oe");
    stop_test;
  end
endmodule // testbench
